/* design/psmc_ctrl.sv */
// Power-save mode controller: sleep, idle, wake-up and oscillator selection.
//
// Summary of operation
// - Oscillator selection written only while unlocked.
// - Low-power state entered only by instruction.
// - Sleep stops clocks and halts execution.
// - Idle halts CPU, peripherals keep clocking.
// - Enabled interrupt, watchdog or reset wakes.
// - Watchdog cleared in the first sleep cycle, when enabled.
// - Low-power RC runs in sleep with watchdog.
// - System-clocked peripherals disabled during sleep.
// - Sleep wake restarts with entry clock source.
`timescale 1ns/1ps
module psmc_ctrl
  import psmc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Power-save instruction from the core
  input wire logic saveValid,
  input wire logic saveOperand,
  // Wake sources
  input wire psmc_wake_t wakeSrc,
  input wire logic watchdogEnable,
  // Oscillator selection write
  input wire logic oscWrite,
  input wire logic [15:0] oscWriteData,
  input wire logic clockLocked,
  // Clock and control outputs
  output psmc_clk_t clkCtl,
  output logic watchdogClear,
  output logic [OSC_SEL_W-1:0] nextOscSelect,
  output logic [OSC_SEL_W-1:0] activeOscSelect,
  output logic asleep,
  output logic idling
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  psmc_state_t state_q, state_d;
  logic [2:0] restartCnt_q, restartCnt_d;
  logic [OSC_SEL_W-1:0] nextOsc_q, activeOsc_q;
  logic wdClear_q;

  // Wake detection is a plain OR of levels, so it needs no edge of the stopped clock.
  wire logic wakeNow = wakeSrc.intr | wakeSrc.watchdog;
  wire logic enterSleep = (state_q == PSMC_RUN) && saveValid && (saveOperand == SAVE_OP_SLEEP);
  wire logic enterIdle = (state_q == PSMC_RUN) && saveValid && (saveOperand == SAVE_OP_IDLE);
  wire logic oscAccept = oscWrite && !clockLocked && (state_q == PSMC_RUN);
  wire logic restartDone = (state_q == PSMC_RESTART) && (restartCnt_q == RESTART_LAST);

  always_comb begin
    state_d = state_q;
    restartCnt_d = '0;
    unique case (state_q)
      PSMC_RUN: begin
        if (enterSleep) begin
          state_d = PSMC_SLEEP;
        end else if (enterIdle) begin
          state_d = PSMC_IDLE;
        end
      end
      PSMC_SLEEP: begin
        if (wakeNow) begin
          state_d = PSMC_RESTART;
        end
      end
      PSMC_IDLE: begin
        if (wakeNow) begin
          state_d = PSMC_RUN;
        end
      end
      PSMC_RESTART: begin
        restartCnt_d = restartCnt_q + 3'h1;
        if (restartDone) begin
          state_d = PSMC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= PSMC_RUN;
      restartCnt_q <= '0;
      nextOsc_q <= OSC_SEL_RESET;
      activeOsc_q <= OSC_SEL_RESET;
      wdClear_q <= 1'b0;
    end else begin
      state_q <= state_d;
      restartCnt_q <= restartCnt_d;
      if (oscAccept) begin
        nextOsc_q <= oscWriteData[OSC_SEL_LSB +: OSC_SEL_W];
      end
      // The active source is frozen outside run, so sleep wakes on the entry source.
      if (state_q == PSMC_RUN && !enterSleep) begin
        activeOsc_q <= nextOsc_q;
      end
      wdClear_q <= enterSleep && watchdogEnable;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire logic inSleep = (state_q == PSMC_SLEEP);
  wire logic inIdle = (state_q == PSMC_IDLE);
  assign clkCtl.sysOscEn = !inSleep;
  assign clkCtl.cpuClkEn = (state_q == PSMC_RUN);
  assign clkCtl.periphClkEn = !inSleep;
  assign clkCtl.lowPowerRcEn = !inSleep || watchdogEnable;
  assign watchdogClear = wdClear_q;
  assign nextOscSelect = nextOsc_q;
  assign activeOscSelect = activeOsc_q;
  assign asleep = inSleep;
  assign idling = inIdle;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_enter_only_by_instr;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == PSMC_RUN && !saveValid) |=> (state_q == PSMC_RUN);
  endproperty
  a_enter_only_by_instr: assert property (p_enter_only_by_instr)
    else $error("Low-power state entered without instruction.");

  property p_osc_locked;
    @(posedge ref_clk) disable iff (!rst_n)
      clockLocked |=> $stable(nextOscSelect);
  endproperty
  a_osc_locked: assert property (p_osc_locked)
    else $error("Oscillator selection changed while locked.");

  property p_sleep_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
      asleep |-> (!clkCtl.sysOscEn && !clkCtl.cpuClkEn && !clkCtl.periphClkEn);
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks)
    else $error("Clock running during sleep.");

  property p_idle_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
      idling |-> (!clkCtl.cpuClkEn && clkCtl.periphClkEn);
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("Idle clocking wrong.");

  property p_idle_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (idling && (wakeSrc.intr || wakeSrc.watchdog)) |=> (state_q == PSMC_RUN);
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("Idle did not wake.");

  property p_wd_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (enterSleep && watchdogEnable) |=> (watchdogClear && asleep);
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("Watchdog not cleared on sleep entry.");

  property p_low_power_rc_clock;
    @(posedge ref_clk) disable iff (!rst_n)
      (asleep && watchdogEnable) |-> clkCtl.lowPowerRcEn;
  endproperty
  a_low_power_rc_clock: assert property (p_low_power_rc_clock)
    else $error("Low-power RC stopped in sleep.");

  property p_same_source;
    @(posedge ref_clk) disable iff (!rst_n)
      asleep |=> $stable(activeOscSelect);
  endproperty
  a_same_source: assert property (p_same_source)
    else $error("Clock source changed across sleep.");

  property p_restart_order;
    @(posedge ref_clk) disable iff (!rst_n)
      (asleep && wakeSrc.intr) |=> (clkCtl.sysOscEn && !clkCtl.cpuClkEn) [*4] ##1 clkCtl.cpuClkEn;
  endproperty
  a_restart_order: assert property (p_restart_order)
    else $error("CPU released before clock restart.");

  property p_sleep_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (asleep && (wakeSrc.intr || wakeSrc.watchdog)) |=> !asleep;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("Sleep did not wake.");

  property p_restart_clocks;
    @(posedge ref_clk) disable iff (!rst_n)
      (state_q == PSMC_RESTART) |->
        (clkCtl.sysOscEn && clkCtl.periphClkEn && !clkCtl.cpuClkEn);
  endproperty
  a_restart_clocks: assert property (p_restart_clocks)
    else $error("CPU clock released during oscillator restart.");

  // Writes are accepted only in the run state, so a halted core must leave the selection alone.
  property p_osc_halted;
    @(posedge ref_clk) disable iff (!rst_n)
      !clkCtl.cpuClkEn |=> $stable(nextOscSelect);
  endproperty
  a_osc_halted: assert property (p_osc_halted)
    else $error("Oscillator selection changed while the core was halted.");

  property p_no_stray_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      !(enterSleep && watchdogEnable) |=> !watchdogClear;
  endproperty
  a_no_stray_clear: assert property (p_no_stray_clear)
    else $error("Watchdog cleared without sleep entry.");

  property p_entry_source;
    @(posedge ref_clk) disable iff (!rst_n)
      enterSleep |=> $stable(activeOscSelect);
  endproperty
  a_entry_source: assert property (p_entry_source)
    else $error("Clock source changed at sleep entry.");

  c_sleep: cover property (@(posedge ref_clk) disable iff (!rst_n)
    enterSleep ##[1:50] state_q == PSMC_RUN);
  c_idle: cover property (@(posedge ref_clk) disable iff (!rst_n)
    enterIdle ##[1:50] state_q == PSMC_RUN);
  c_osc: cover property (@(posedge ref_clk) disable iff (!rst_n) oscAccept);
  c_wdt_wake: cover property (@(posedge ref_clk) disable iff (!rst_n)
    asleep && wakeSrc.watchdog);
  c_locked_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    oscWrite && clockLocked);

endmodule : psmc_ctrl

/* include/psmc_pkg.sv */
// Package for the power-save mode controller: modes, states and field layouts.
package psmc_pkg;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int OSC_SEL_W = 3;
  localparam int OSC_SEL_LSB = 8;
  localparam logic [OSC_SEL_W-1:0] OSC_SEL_RESET = 3'h0;
  localparam int RESTART_CYCLES = 4;
  localparam logic [2:0] RESTART_LAST = 3'(RESTART_CYCLES - 1);

  // ----------------------------------------------------------------
  // Power-save instruction operand
  // ----------------------------------------------------------------
  localparam logic SAVE_OP_SLEEP = 1'h0;
  localparam logic SAVE_OP_IDLE = 1'h1;

  typedef enum logic [1:0] {
    PSMC_RUN,
    PSMC_SLEEP,
    PSMC_IDLE,
    PSMC_RESTART
  } psmc_state_t;

  typedef struct packed {
    logic cpuClkEn;
    logic periphClkEn;
    logic sysOscEn;
    logic lowPowerRcEn;
  } psmc_clk_t;

  typedef struct packed {
    logic intr;
    logic watchdog;
  } psmc_wake_t;

endpackage : psmc_pkg

/* test/psmc_core_model.sv */
// Core model that issues the power-save instruction.
`timescale 1ns/1ps
module psmc_core_model (
  // Clock
  input wire logic ref_clk,
  // Instruction
  output logic saveValid,
  output logic saveOperand
);
  initial begin
    saveValid = 1'b0;
    saveOperand = 1'b0;
  end
  // The operand flips after the pulse, so a stale value is never trusted.
  task automatic issue(input logic op);
    @(negedge ref_clk);
    saveValid = 1'b1;
    saveOperand = op;
    @(negedge ref_clk);
    saveValid = 1'b0;
    saveOperand = ~op;
  endtask : issue
endmodule : psmc_core_model

/* test/test_power_save_mode_control.sv */
// Self-checking bench for the power-save mode controller.
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_power_save_mode_control
  import psmc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic watchdogEnable = 1'b1;
  logic oscWrite = 1'b0;
  logic clockLocked = 1'b0;
  logic [15:0] oscWriteData = 16'h0000;
  psmc_wake_t wakeSrc = '0;
  psmc_clk_t clkCtl;
  logic saveValid, saveOperand, watchdogClear, asleep, idling;
  logic [OSC_SEL_W-1:0] nextOscSelect, activeOscSelect;
  int mismatches = 0;
  int cmp_count = 0;
  psmc_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .saveValid(saveValid),
    .saveOperand(saveOperand), .wakeSrc(wakeSrc), .watchdogEnable(watchdogEnable),
    .oscWrite(oscWrite), .oscWriteData(oscWriteData), .clockLocked(clockLocked),
    .clkCtl(clkCtl), .watchdogClear(watchdogClear), .nextOscSelect(nextOscSelect),
    .activeOscSelect(activeOscSelect), .asleep(asleep), .idling(idling));
  psmc_core_model i_core (.ref_clk(ref_clk), .saveValid(saveValid),
    .saveOperand(saveOperand));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic osc_write(input logic [15:0] data, input logic lock);
    @(negedge ref_clk);
    oscWrite = 1'b1;
    oscWriteData = data;
    clockLocked = lock;
    cyc(1);
    oscWrite = 1'b0;
    cyc(1);
  endtask : osc_write
  // Sleep entry, a refused write while asleep, then wake through the restart.
  task automatic sleep_wake();
    osc_write(16'h0500, 1'b0);
    `CHK("nextOsc", 3'h5, nextOscSelect)
    `CHK("activeOsc", 3'h5, activeOscSelect)
    osc_write(16'h0200, 1'b1);
    `CHK("lockedOsc", 3'h5, nextOscSelect)
    i_core.issue(SAVE_OP_SLEEP);
    `CHK("asleep", 1'b1, asleep)
    `CHK("wdtClear", 1'b1, watchdogClear)
    `CHK("sleepClk", 4'h1, clkCtl)
    osc_write(16'h0700, 1'b0);
    `CHK("sleepOsc", 3'h5, nextOscSelect)
    wakeSrc.intr = 1'b1;
    cyc(1);
    wakeSrc.intr = 1'b0;
    `CHK("wakeSleep", 1'b0, asleep)
    for (int i = 0; i < RESTART_CYCLES; i++) begin
      `CHK("restartClk", 4'h7, clkCtl)
      cyc(1);
    end
    `CHK("runClk", 4'hF, clkCtl)
    `CHK("entryOsc", 3'h5, activeOscSelect)
  endtask : sleep_wake
  task automatic idle_wake();
    i_core.issue(SAVE_OP_IDLE);
    `CHK("idling", 1'b1, idling)
    `CHK("idleClk", 4'h7, clkCtl)
    `CHK("idleClear", 1'b0, watchdogClear)
    wakeSrc.watchdog = 1'b1;
    cyc(1);
    wakeSrc.watchdog = 1'b0;
    `CHK("wakeIdle", 1'b0, idling)
    `CHK("idleRun", 4'hF, clkCtl)
  endtask : idle_wake
  // Sleep left through a watchdog time-out, then idle left through an interrupt.
  task automatic other_wakes();
    i_core.issue(SAVE_OP_SLEEP);
    wakeSrc.watchdog = 1'b1;
    cyc(1);
    wakeSrc.watchdog = 1'b0;
    `CHK("wdtWakeSleep", 1'b0, asleep)
    `CHK("wdtRestartClk", 4'h7, clkCtl)
    cyc(RESTART_CYCLES);
    `CHK("wdtWakeRun", 4'hF, clkCtl)
    i_core.issue(SAVE_OP_IDLE);
    wakeSrc.intr = 1'b1;
    cyc(1);
    wakeSrc.intr = 1'b0;
    `CHK("intrWakeIdle", 1'b0, idling)
  endtask : other_wakes
  task automatic reset_wake();
    watchdogEnable = 1'b0;
    i_core.issue(SAVE_OP_SLEEP);
    `CHK("noRcClk", 4'h0, clkCtl)
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    `CHK("resetWake", 1'b0, asleep)
    `CHK("resetClk", 4'hF, clkCtl)
  endtask : reset_wake
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    cyc(3);
    rst_n = 1'b1;
    sleep_wake();
    idle_wake();
    other_wakes();
    reset_wake();
    results();
  end
endmodule : test_power_save_mode_control
